// ### hdl/pdp_pin_sync.sv
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pdp_pin_sync #(
	parameter int WIDTH = 6
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_level
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
	wire [WIDTH-1:0] level_next = (agree & s2_reg) | (~agree & level_reg);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign pin_level = level_reg;
endmodule : pdp_pin_sync
`default_nettype wire

// ### hdl/pdp_pkg.sv
// Package of offsets, layouts and reset values for the port direction and output port block
package pdp_pkg;
	localparam logic [15:0] PDP_DIR0_ADDR = 16'hff20;
	localparam logic [15:0] PDP_DIR1_ADDR = 16'hff21;
	localparam logic [15:0] PDP_DIR2_ADDR = 16'hff22;
	localparam logic [15:0] PDP_DIR3_ADDR = 16'hff23;
	localparam logic [15:0] PDP_DIR4_ADDR = 16'hff24;
	localparam logic [15:0] PDP_DIR6_ADDR = 16'hff26;
	localparam logic [15:0] PDP_DIR7_ADDR = 16'hff27;
	localparam logic [15:0] PDP_DIR12_ADDR = 16'hff2c;
	localparam logic [15:0] PDP_DIR14_ADDR = 16'hff2e;
	// Latch, pull-up and analog config registers sit in a local window
	localparam logic [15:0] PDP_ECHO_LATCH_ADDR = 16'hff0d;
	localparam logic [15:0] PDP_BIDIR_LATCH_ADDR = 16'hff0e;
	localparam logic [15:0] PDP_BIDIR_PULLUP_ADDR = 16'hff3e;
	localparam logic [15:0] PDP_ANALOG_CFG_ADDR = 16'hff2f;
	// Implemented bits per direction bank; other bits are fixed at one
	localparam logic [7:0] PDP_DIR0_MASK = 8'h0f;
	localparam logic [7:0] PDP_DIR1_MASK = 8'hff;
	localparam logic [7:0] PDP_DIR2_MASK = 8'hff;
	localparam logic [7:0] PDP_DIR3_MASK = 8'h0f;
	localparam logic [7:0] PDP_DIR4_MASK = 8'h03;
	localparam logic [7:0] PDP_DIR6_MASK = 8'h0f;
	localparam logic [7:0] PDP_DIR7_MASK = 8'hff;
	localparam logic [7:0] PDP_DIR12_MASK = 8'h1f;
	localparam logic [7:0] PDP_DIR14_MASK = 8'h3f;
	localparam logic [7:0] PDP_DIR_RESET = 8'hff;
	localparam logic [7:0] PDP_LATCH_RESET = 8'h00;
	localparam logic [7:0] PDP_PULLUP_RESET = 8'h00;
	localparam logic [7:0] PDP_ANALOG_RESET = 8'h00;
	localparam logic PDP_ECHO_RESET = 1'b0;
	localparam int PDP_BIDIR_BITS = 6;
	localparam int PDP_DIR_BANKS = 9;
endpackage : pdp_pkg

// ### hdl/pdp_port_block.sv
// Port direction bank, reset-echo output port and bidirectional port
//
// What this block does
// - The reset-echo port is output only: its pin follows its latch outside reset, with no input mode.
// - While reset is applied the reset-echo pin is driven low regardless of the latch.
// - The bidirectional port has an output latch and per-bit input/output choice from its direction bits.
// - A bidirectional pin in input mode gets its pull-up when its pull-up select bit is set.
// - Reset puts every bidirectional pin in input mode.
// - Bidirectional pins are shared with interrupt, buzzer, clock-out and serial functions.
// - Port behaviour is set by direction, latch, pull-up select and one analog config register.
// - Direction registers choose mode per pin and take bit and byte writes.
// - Reset loads every direction register with all ones.
// - A direction bit of zero turns the output buffer on and drives the latch value, or the alternate value where alt_out_sel is set.
// - A direction bit of one turns the output buffer off; the pin floats unless its pull-up select bit is set.
`timescale 1ns/1ps
`default_nettype none
module pdp_port_block
	import pdp_pkg::*;
#(
	parameter int BIDIR_BITS = PDP_BIDIR_BITS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic cpu_bit_op,
	input wire logic [2:0] cpu_bit_sel,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_hit,
	output logic reset_echo_pin,
	input wire logic [BIDIR_BITS-1:0] bidir_pin_in,
	output logic [BIDIR_BITS-1:0] bidir_pin_out,
	output logic [BIDIR_BITS-1:0] bidir_pin_oe,
	output logic [BIDIR_BITS-1:0] bidir_pullup_en,
	input wire logic [BIDIR_BITS-1:0] alt_out_sel,
	input wire logic [BIDIR_BITS-1:0] alt_out_val,
	output logic [BIDIR_BITS-1:0] alt_in_level,
	output logic [7:0] analog_pin_config,
	output logic [7:0] dir_bank_0,
	output logic [7:0] dir_bank_1,
	output logic [7:0] dir_bank_2,
	output logic [7:0] dir_bank_3,
	output logic [7:0] dir_bank_4,
	output logic [7:0] dir_bank_6,
	output logic [7:0] dir_bank_7,
	output logic [7:0] dir_bank_12
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Merge a bit or byte write into a register, keeping fixed-one bits
	function automatic logic [7:0] pdp_merge(input logic [7:0] old_val, input logic [7:0] mask,
		input logic bit_op, input logic [2:0] bsel, input logic [7:0] wdata);
		logic [7:0] upd;
		upd = old_val;
		if (bit_op) begin
			upd[bsel] = wdata[0];
		end else begin
			upd = wdata;
		end
		pdp_merge = (upd & mask) | ~mask;
	endfunction : pdp_merge

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0] dir_reg [PDP_DIR_BANKS];
	logic [7:0] dir_next [PDP_DIR_BANKS];
	logic reset_echo_latch_reg;
	logic [7:0] bidir_port_latch_reg;
	logic [7:0] bidir_port_pullup_reg;
	logic [7:0] analog_pin_config_reg;
	logic [7:0] cpu_rdata_reg;
	logic cpu_hit_reg;
	logic reset_echo_pin_reg;
	logic [BIDIR_BITS-1:0] bidir_pin_out_reg;
	logic [BIDIR_BITS-1:0] bidir_pin_oe_reg;
	logic [BIDIR_BITS-1:0] bidir_pullup_en_reg;
	logic [BIDIR_BITS-1:0] pin_level;

	localparam logic [15:0] DIR_ADDR [PDP_DIR_BANKS] = '{PDP_DIR0_ADDR, PDP_DIR1_ADDR, PDP_DIR2_ADDR,
		PDP_DIR3_ADDR, PDP_DIR4_ADDR, PDP_DIR6_ADDR, PDP_DIR7_ADDR, PDP_DIR12_ADDR, PDP_DIR14_ADDR};
	localparam logic [7:0] DIR_MASK [PDP_DIR_BANKS] = '{PDP_DIR0_MASK, PDP_DIR1_MASK, PDP_DIR2_MASK,
		PDP_DIR3_MASK, PDP_DIR4_MASK, PDP_DIR6_MASK, PDP_DIR7_MASK, PDP_DIR12_MASK, PDP_DIR14_MASK};
	localparam int BIDIR_IDX = 8;

	pdp_pin_sync #(.WIDTH(BIDIR_BITS)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(bidir_pin_in),
		.pin_level(pin_level)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic [PDP_DIR_BANKS-1:0] dir_hit;
	for (genvar g = 0; g < PDP_DIR_BANKS; g++) begin : g_dir
		assign dir_hit[g] = (cpu_addr == DIR_ADDR[g]);
		assign dir_next[g] = (cpu_wr && dir_hit[g]) ?
			pdp_merge(dir_reg[g], DIR_MASK[g], cpu_bit_op, cpu_bit_sel, cpu_wdata) : dir_reg[g];
	end

	wire echo_hit = (cpu_addr == PDP_ECHO_LATCH_ADDR);
	wire latch_hit = (cpu_addr == PDP_BIDIR_LATCH_ADDR);
	wire pullup_hit = (cpu_addr == PDP_BIDIR_PULLUP_ADDR);
	wire analog_hit = (cpu_addr == PDP_ANALOG_CFG_ADDR);
	wire any_hit = (|dir_hit) | echo_hit | latch_hit | pullup_hit | analog_hit;

	localparam logic [7:0] BIDIR_MASK = 8'(({8{1'b1}} << BIDIR_BITS) ^ 8'hff);
	wire [7:0] echo_word = {7'h00, reset_echo_latch_reg};
	wire [7:0] echo_next8 = pdp_merge(echo_word, 8'h01, cpu_bit_op, cpu_bit_sel, cpu_wdata) & 8'h01;
	wire [7:0] latch_next8 = pdp_merge(bidir_port_latch_reg, BIDIR_MASK, cpu_bit_op, cpu_bit_sel, cpu_wdata)
		& BIDIR_MASK;
	wire [7:0] pullup_next8 = pdp_merge(bidir_port_pullup_reg, BIDIR_MASK, cpu_bit_op, cpu_bit_sel, cpu_wdata)
		& BIDIR_MASK;
	wire [7:0] analog_next8 = pdp_merge(analog_pin_config_reg, 8'hff, cpu_bit_op, cpu_bit_sel, cpu_wdata);

	// ----------------------------------------------------------------
	// Pin-side logic
	// ----------------------------------------------------------------
	wire [BIDIR_BITS-1:0] bidir_dir = dir_reg[BIDIR_IDX][BIDIR_BITS-1:0];
	wire [BIDIR_BITS-1:0] latch_bits = bidir_port_latch_reg[BIDIR_BITS-1:0];
	// Alternate outputs take over the drive value but never the buffer enable
	wire [BIDIR_BITS-1:0] drive_val = (alt_out_sel & alt_out_val) | (~alt_out_sel & latch_bits);
	wire [BIDIR_BITS-1:0] oe_next = ~bidir_dir;
	wire [BIDIR_BITS-1:0] pullup_next = bidir_dir & bidir_port_pullup_reg[BIDIR_BITS-1:0];
	wire [BIDIR_BITS-1:0] bidir_read = (bidir_dir & pin_level) | (~bidir_dir & latch_bits);

	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < PDP_DIR_BANKS; i++) begin
			if (dir_hit[i]) begin
				rd_mux = dir_reg[i];
			end
		end
		if (echo_hit) begin
			rd_mux = echo_word;
		end
		if (latch_hit) begin
			rd_mux = {{(8-BIDIR_BITS){1'b0}}, bidir_read};
		end
		if (pullup_hit) begin
			rd_mux = bidir_port_pullup_reg;
		end
		if (analog_hit) begin
			rd_mux = analog_pin_config_reg;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < PDP_DIR_BANKS; i++) begin
				dir_reg[i] <= PDP_DIR_RESET;
			end
		end else begin
			for (int i = 0; i < PDP_DIR_BANKS; i++) begin
				dir_reg[i] <= dir_next[i];
			end
		end
	end

	// The echo latch survives reset on purpose so a pre-armed high shows after release
	always_ff @(posedge core_clk) begin
		if (cpu_wr && echo_hit) begin
			reset_echo_latch_reg <= echo_next8[0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bidir_port_latch_reg <= PDP_LATCH_RESET;
			bidir_port_pullup_reg <= PDP_PULLUP_RESET;
			analog_pin_config_reg <= PDP_ANALOG_RESET;
		end else begin
			if (cpu_wr && latch_hit) begin
				bidir_port_latch_reg <= latch_next8;
			end
			if (cpu_wr && pullup_hit) begin
				bidir_port_pullup_reg <= pullup_next8;
			end
			if (cpu_wr && analog_hit) begin
				analog_pin_config_reg <= analog_next8;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_echo_pin_reg <= PDP_ECHO_RESET;
			bidir_pin_out_reg <= '0;
			bidir_pin_oe_reg <= '0;
			bidir_pullup_en_reg <= '0;
			cpu_rdata_reg <= 8'h00;
			cpu_hit_reg <= 1'b0;
		end else begin
			reset_echo_pin_reg <= reset_echo_latch_reg;
			bidir_pin_out_reg <= drive_val;
			bidir_pin_oe_reg <= oe_next;
			bidir_pullup_en_reg <= pullup_next;
			cpu_rdata_reg <= cpu_rd ? rd_mux : 8'h00;
			cpu_hit_reg <= (cpu_rd | cpu_wr) & any_hit;
		end
	end

	assign cpu_rdata = cpu_rdata_reg;
	assign cpu_hit = cpu_hit_reg;
	assign reset_echo_pin = reset_echo_pin_reg;
	assign bidir_pin_out = bidir_pin_out_reg;
	assign bidir_pin_oe = bidir_pin_oe_reg;
	assign bidir_pullup_en = bidir_pullup_en_reg;
	assign alt_in_level = pin_level;
	assign analog_pin_config = analog_pin_config_reg;
	assign dir_bank_0 = dir_reg[0];
	assign dir_bank_1 = dir_reg[1];
	assign dir_bank_2 = dir_reg[2];
	assign dir_bank_3 = dir_reg[3];
	assign dir_bank_4 = dir_reg[4];
	assign dir_bank_6 = dir_reg[5];
	assign dir_bank_7 = dir_reg[6];
	assign dir_bank_12 = dir_reg[7];
endmodule : pdp_port_block
`default_nettype wire

// ### verification/pdp_board.sv
// Board model driving the bidirectional port pins
`timescale 1ns/1ps
`default_nettype none
module pdp_board (
	input wire logic clk,
	input wire logic [5:0] out, oe, pu, ext_en, ext_val,
	output logic [5:0] pin
);
	logic [5:0] tog = 6'h15;
	// A floating pin without pull-up wanders each clock, so the agreement filter holds its last agreed level
	always @(posedge clk) tog <= ~tog;
	always_comb for (int i = 0; i < 6; i++)
		pin[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : tog[i];
endmodule : pdp_board
`default_nettype wire

// ### verification/pdp_port_block_props.sv
// Checker for the port direction and output port block
`timescale 1ns/1ps
`default_nettype none
module pdp_port_block_props
	import pdp_pkg::*;
#(
	parameter int BIDIR_BITS = 6
) (
	input wire logic core_clk, rst_n, cpu_wr, cpu_rd, cpu_bit_op, cpu_hit, reset_echo_pin,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_wdata, cpu_rdata, dir_bank_0, dir_bank_1, dir_bank_4,
	input wire logic [BIDIR_BITS-1:0] bidir_pin_out, bidir_pin_oe, bidir_pullup_en, alt_out_sel, alt_out_val
);
	wire acc = cpu_wr | cpu_rd;
	wire mapped = cpu_addr inside {16'hff0d, 16'hff0e, 16'hff3e, 16'hff2f, 16'hff20, 16'hff21, 16'hff22,
		16'hff23, 16'hff24, 16'hff26, 16'hff27, 16'hff2c, 16'hff2e};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_HIT: assert property (acc |=> cpu_hit == $past(mapped)) else $error("hit flag wrong");
	AST_UNMAPPED: assert property (acc && !mapped |=> cpu_rdata == 8'h00) else $error("unmapped read data");
	AST_IDLE: assert property (!acc |=> !cpu_hit && cpu_rdata == 8'h00) else $error("answer without access");
	AST_FIXED: assert property ((dir_bank_0 | PDP_DIR0_MASK) == 8'hff && (dir_bank_4 | PDP_DIR4_MASK) == 8'hff)
		else $error("fixed direction bits not one");
	AST_BYTE_WR: assert property (cpu_wr && !cpu_bit_op && cpu_addr == PDP_DIR1_ADDR |=> dir_bank_1 == $past(cpu_wdata))
		else $error("direction byte write lost");
	AST_PU_IN_ONLY: assert property ((bidir_pin_oe & bidir_pullup_en) == '0) else $error("pull-up on output");
	AST_OUT_RESET: assert property ($rose(rst_n) |-> bidir_pin_oe == '0 && dir_bank_0 == 8'hff)
		else $error("port not input after reset");
	AST_ECHO_RST: assert property (disable iff (1'b0) !rst_n |-> !reset_echo_pin) else $error("echo pin high in reset");
	AST_ECHO_WR: assert property (cpu_wr && !cpu_bit_op && cpu_addr == PDP_ECHO_LATCH_ADDR |-> ##2
		reset_echo_pin == $past(cpu_wdata[0], 2)) else $error("echo pin not from latch");
	AST_ALT: assert property ($past(rst_n) |-> ((bidir_pin_out ^ $past(alt_out_val)) & $past(alt_out_sel)) == '0)
		else $error("alternate output not driven");
	AST_LATCH_OUT: assert property (cpu_wr && !cpu_bit_op && cpu_addr == PDP_BIDIR_LATCH_ADDR ##1
		!(cpu_wr && cpu_addr == PDP_BIDIR_LATCH_ADDR) |=>
		((bidir_pin_out ^ $past(cpu_wdata[BIDIR_BITS-1:0], 2)) & ~$past(alt_out_sel)) == '0)
		else $error("latch value not driven");
	cover property (cpu_wr && cpu_bit_op);
	cover property ($rose(rst_n));
	cover property (bidir_pullup_en != '0);
endmodule : pdp_port_block_props
bind pdp_port_block pdp_port_block_props #(.BIDIR_BITS(BIDIR_BITS)) props_i (.core_clk, .rst_n, .cpu_wr, .cpu_rd,
	.cpu_bit_op, .cpu_hit, .reset_echo_pin, .cpu_addr, .cpu_wdata, .cpu_rdata, .dir_bank_0, .dir_bank_1, .dir_bank_4,
	.bidir_pin_out, .bidir_pin_oe, .bidir_pullup_en, .alt_out_sel, .alt_out_val);
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the port direction and output port block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk = 0, rst_n, cpu_wr = 0, cpu_rd = 0, cpu_bit_op = 0, cpu_hit, reset_echo_pin;
	logic [2:0] cpu_bit_sel = 0;
	logic [15:0] cpu_addr = 0;
	logic [7:0] cpu_wdata = 0, cpu_rdata, analog_pin_config;
	logic [5:0] bidir_pin_in, bidir_pin_out, bidir_pin_oe, bidir_pullup_en, alt_in_level;
	logic [5:0] alt_out_sel = 0, alt_out_val = 0, ext_en = 0, ext_val = 0;
	int fails = 0, check_count = 0, cyc = 0;
	logic [15:0] da[9] = '{16'hff20, 16'hff21, 16'hff22, 16'hff23, 16'hff24, 16'hff26, 16'hff27, 16'hff2c, 16'hff2e};
	logic [7:0] dm[9] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'h03, 8'h0f, 8'hff, 8'h1f, 8'h3f};
	pdp_port_block pdp_port_block_i (.core_clk(core_clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_bit_op(cpu_bit_op), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .reset_echo_pin(reset_echo_pin), .bidir_pin_in(bidir_pin_in),
		.bidir_pin_out(bidir_pin_out), .bidir_pin_oe(bidir_pin_oe), .bidir_pullup_en(bidir_pullup_en),
		.alt_out_sel(alt_out_sel), .alt_out_val(alt_out_val), .alt_in_level(alt_in_level),
		.analog_pin_config(analog_pin_config), .dir_bank_0(), .dir_bank_1(), .dir_bank_2(), .dir_bank_3(),
		.dir_bank_4(), .dir_bank_6(), .dir_bank_7(), .dir_bank_12());
	pdp_board pdp_board_i (.clk(core_clk), .out(bidir_pin_out), .oe(bidir_pin_oe), .pu(bidir_pullup_en),
		.ext_en, .ext_val, .pin(bidir_pin_in));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		#1 {alt_out_sel, alt_out_val} <= 12'($urandom);
		if (++cyc == 5000) begin
			fails++;
			end_of_test();
		end
	end
	function automatic logic [7:0] fix(input int k, input logic [7:0] v);
		return v | ~dm[k];
	endfunction : fix
	task automatic end_of_test();
		if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 0, input logic [2:0] s = 0);
		@(posedge core_clk) #1;
		{cpu_wr, cpu_rd, cpu_addr, cpu_wdata, cpu_bit_op, cpu_bit_sel} = {2'b10, a, d, b, s};
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h = 1);
		@(posedge core_clk) #1;
		{cpu_wr, cpu_rd, cpu_addr} = {2'b01, a};
		@(posedge core_clk) #1;
		cpu_rd = 0;
		chk("rdata", e, cpu_rdata);
		chk("hit", {7'h0, h}, {7'h0, cpu_hit});
	endtask : rd
	task automatic idle(input int n);
		@(posedge core_clk) #1;
		{cpu_wr, cpu_rd} = 2'b00;
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle
	initial begin
		logic [7:0] d, l;
		logic [5:0] p;
		d = 8'($urandom(32'h4395));
		// A real falling edge so the asynchronous reset branches fire before the first clock
		#1 rst_n = 0;
		repeat (12) @(posedge core_clk);
		#1 rst_n = 1;
		for (int k = 0; k < 9; k++) rd(da[k], 8'hff);
		rd(16'hff25, 8'h00, 0);
		repeat (3) for (int k = 0; k < 9; k++) begin
			d = 8'($urandom);
			wr(da[k], d);
			rd(da[k], fix(k, d));
		end
		wr(da[8], 8'hff);
		l = 8'hff;
		for (int i = 0; i < 8; i++) begin
			l[i] = 1'($urandom);
			wr(da[8], {7'h0, l[i]}, 1, 3'(i));
		end
		rd(da[8], fix(8, l));
		l = 8'($urandom);
		wr(16'hff0e, l);
		wr(da[8], 8'h00);
		idle(2);
		chk("oe", 8'h3f, {2'b0, bidir_pin_oe});
		rd(16'hff0e, {2'b0, l[5:0]});
		ext_en = 6'h2a;
		ext_val = 6'($urandom);
		p = ext_val & 6'h2a | 6'h15;
		wr(16'hff3e, 8'h15);
		wr(da[8], 8'hff);
		idle(6);
		chk("oe", 8'h00, {2'b0, bidir_pin_oe});
		chk("pullup", 8'h15, {2'b0, bidir_pullup_en});
		chk("level", {2'b0, p}, {2'b0, alt_in_level});
		rd(16'hff0e, {2'b0, p});
		wr(da[8], 8'hf0);
		idle(6);
		chk("pullup", 8'h10, {2'b0, bidir_pullup_en});
		rd(16'hff0e, {2'b0, p[5:4], l[3:0]});
		d = 8'($urandom);
		wr(16'hff2f, d);
		rd(16'hff2f, d);
		chk("analog", d, analog_pin_config);
		wr(16'hff0d, 8'h01);
		idle(2);
		chk("echo", 8'h01, {7'h0, reset_echo_pin});
		rst_n = 0;
		#1 chk("echo", 8'h00, {7'h0, reset_echo_pin});
		@(posedge core_clk) #1 rst_n = 1;
		idle(1);
		chk("echo", 8'h01, {7'h0, reset_echo_pin});
		chk("oe", 8'h00, {2'b0, bidir_pin_oe});
		rd(da[4], 8'hff);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
